// >>> hdl/wake_reset_strap_control.sv
// Operation
// - The block runs from a 100 MHz reference, by crystal or oscillator, divided down to a 25 MHz tick.
// - Holding the low reset returns all logic and registers to reset.
// - After reset or sleep, writes are ignored until one read occurs.
// - When enabled, a wake event asserts the wake indicator output.
// - Wake indicator polarity and push-pull/open-drain are programmable.
// - Asserting the wake indicator does not leave the sleep state.
// - Only a host write cycle, any data, leaves the sleep state.
// - Auto crossover follows its enable input, low when left open.
// - The speed strap is latched at reset release and held.
`default_nettype none
module wake_reset_strap_control
  import wake_ctrl_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // register port
  input wire wake_ctrl_pkg::bus_req_t busReq,
  output logic [31:0] rdData,
  // pins
  input wire logic speedSelPin,
  input wire logic crossoverAutoEnablePin,
  input wire logic wakeEventIn,
  output logic wakeIndicatorOut,
  output logic wakeIndicatorOe_n,
  // status
  output wake_ctrl_pkg::link_cfg_t linkCfg,
  output logic sleeping,
  output logic oscTick,
  output logic irq
);
  import wake_ctrl_pkg::*;

  logic speedSync;
  logic xoverSync;
  logic wakeSync;
  logic tick;

  sync_two #(.W(3)) u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .din({speedSelPin, crossoverAutoEnablePin, wakeEventIn}),
    .dout({speedSync, xoverSync, wakeSync})
  );

  osc_div #(.DIV(OSC_DIV)) u_div (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .tick(tick)
  );

  pwr_state_t state_ff, nxt_state;
  logic [3:0] ctrl_ff, nxt_ctrl;
  logic [1:0] irqStat_ff, nxt_irqStat;
  logic [1:0] irqMask_ff, nxt_irqMask;
  logic [31:0] rdData_ff, nxt_rdData;
  logic strapDone_ff, nxt_strapDone;
  logic strap_ff, nxt_strap;
  logic xover_ff;
  logic wakeReq_ff, nxt_wakeReq;
  logic wakeOut_ff, nxt_wakeOut;
  logic wakeOe_ff, nxt_wakeOe;
  logic irq_ff;
  logic tick_ff;
  logic wakeSyncD_ff;
  logic wakeEdge;
  logic wrOk;
  logic sleep_ff;
  logic [1:0] strapCnt_ff, nxt_strapCnt;

  assign wakeEdge = wakeSync & ~wakeSyncD_ff;
  assign wrOk = busReq.wr && (state_ff == PW_ACTIVE);

  always_comb begin
    nxt_state = state_ff;
    nxt_ctrl = ctrl_ff;
    nxt_irqStat = irqStat_ff;
    nxt_irqMask = irqMask_ff;
    nxt_rdData = '0;
    nxt_wakeReq = wakeReq_ff;
    unique case (state_ff)
      PW_LOCKED: begin
        if (busReq.rd) begin
          nxt_state = PW_ACTIVE;
        end
      end
      PW_ACTIVE: begin
        if (wrOk && busReq.addr == REG_CTRL &&
            busReq.wdata[CTRL_SLEEP]) begin
          nxt_state = PW_SLEEP;
        end
      end
      PW_SLEEP: begin
        if (busReq.wr) begin
          nxt_state = PW_LOCKED;
          nxt_irqStat[IRQ_RESUME] = 1'b1;
        end
      end
      default: nxt_state = PW_LOCKED;
    endcase
    if (wrOk) begin
      unique case (busReq.addr)
        REG_CTRL: nxt_ctrl = busReq.wdata[3:0];
        REG_IRQ_STAT: nxt_irqStat = irqStat_ff & ~busReq.wdata[1:0];
        REG_IRQ_MASK: nxt_irqMask = busReq.wdata[1:0];
        default: ;
      endcase
    end
    if (state_ff == PW_SLEEP && busReq.wr) begin
      nxt_ctrl[CTRL_SLEEP] = 1'b0;
      nxt_wakeReq = 1'b0;
      nxt_irqStat[IRQ_RESUME] = 1'b1;
    end
    if (wrOk && busReq.addr == REG_CTRL &&
        !busReq.wdata[CTRL_WAKE_EN]) begin
      nxt_wakeReq = 1'b0;
    end
    // wake event sets, wins over clear
    if (wakeEdge && ctrl_ff[CTRL_WAKE_EN]) begin
      nxt_wakeReq = 1'b1;
      nxt_irqStat[IRQ_WAKE] = 1'b1;
    end
    if (busReq.rd) begin
      unique case (busReq.addr)
        REG_CTRL: nxt_rdData = {28'h0, ctrl_ff};
        REG_STAT: nxt_rdData = {26'h0, state_ff, wakeReq_ff,
          xover_ff, strap_ff, strapDone_ff};
        REG_IRQ_STAT: nxt_rdData = {30'h0, irqStat_ff};
        REG_IRQ_MASK: nxt_rdData = {30'h0, irqMask_ff};
        REG_BYTE_TEST: nxt_rdData = BYTE_TEST_VAL;
        default: nxt_rdData = '0;
      endcase
    end
  end

  // latch strap once after release
  // sync pipe must fill before the strap is taken
  always_comb begin
    nxt_strapCnt = strapCnt_ff;
    nxt_strapDone = strapDone_ff;
    nxt_strap = strap_ff;
    if (strapCnt_ff != STRAP_WAIT) begin
      nxt_strapCnt = strapCnt_ff + 2'h1;
    end else if (!strapDone_ff) begin
      nxt_strapDone = 1'b1;
      nxt_strap = speedSync;
    end
  end

  always_comb begin
    nxt_wakeOut = wakeReq_ff ^ ~ctrl_ff[CTRL_WAKE_POL];
    nxt_wakeOe = 1'b0;
    if (ctrl_ff[CTRL_WAKE_OD]) begin
      nxt_wakeOut = 1'b0;
      // pulled low only while the pin level is low
      nxt_wakeOe = wakeReq_ff ^ ~ctrl_ff[CTRL_WAKE_POL];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= PW_LOCKED;
      ctrl_ff <= CTRL_RST;
      irqStat_ff <= IRQ_RST;
      irqMask_ff <= IRQ_RST;
      rdData_ff <= '0;
      strapDone_ff <= 1'b0;
      strap_ff <= 1'b0;
      strapCnt_ff <= 2'h0;
      sleep_ff <= 1'b0;
      xover_ff <= 1'b0;
      wakeReq_ff <= 1'b0;
      wakeOut_ff <= 1'b0;
      wakeOe_ff <= 1'b1;
      irq_ff <= 1'b0;
      tick_ff <= 1'b0;
      wakeSyncD_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ctrl_ff <= nxt_ctrl;
      irqStat_ff <= nxt_irqStat;
      irqMask_ff <= nxt_irqMask;
      rdData_ff <= nxt_rdData;
      strapDone_ff <= nxt_strapDone;
      strap_ff <= nxt_strap;
      strapCnt_ff <= nxt_strapCnt;
      sleep_ff <= (nxt_state == PW_SLEEP);
      xover_ff <= xoverSync;
      wakeReq_ff <= nxt_wakeReq;
      wakeOut_ff <= nxt_wakeOut;
      wakeOe_ff <= nxt_wakeOe;
      irq_ff <= |(nxt_irqStat & nxt_irqMask);
      tick_ff <= tick;
      wakeSyncD_ff <= wakeSync;
    end
  end

  assign rdData = rdData_ff;
  assign wakeIndicatorOut = wakeOut_ff;
  assign wakeIndicatorOe_n = wakeOe_ff;
  // strap high means 100 Mbps default
  assign linkCfg = '{strapSpeed100: strap_ff, autoXover: xover_ff};
  assign sleeping = sleep_ff;
  assign oscTick = tick_ff;
  assign irq = irq_ff;

  AST_WR_LOCKED: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    state_ff == PW_LOCKED && busReq.wr && busReq.addr == REG_CTRL
    |=> ctrl_ff == $past(ctrl_ff))
    else $error("write taken before first read");
  AST_RD_UNLOCK: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    state_ff == PW_LOCKED && busReq.rd |=> state_ff == PW_ACTIVE)
    else $error("read did not unlock writes");
  AST_SLEEP_STAY: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    state_ff == PW_SLEEP && !busReq.wr |=> state_ff == PW_SLEEP)
    else $error("left sleep without host write");
  AST_WR_WAKE: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    state_ff == PW_SLEEP && busReq.wr |=> state_ff == PW_LOCKED)
    else $error("write did not wake device");
  AST_RESUME_IRQ: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    state_ff == PW_SLEEP && busReq.wr |=> irqStat_ff[IRQ_RESUME]
    && !sleeping)
    else $error("resume status not set");
  AST_WAKE_REQ: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    wakeEdge && ctrl_ff[CTRL_WAKE_EN] |=> wakeReq_ff
    && irqStat_ff[IRQ_WAKE])
    else $error("wake event not flagged");
  AST_WAKE_PIN: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    !ctrl_ff[CTRL_WAKE_OD] |=> !wakeIndicatorOe_n &&
    wakeIndicatorOut == ($past(wakeReq_ff) ==
    $past(ctrl_ff[CTRL_WAKE_POL])))
    else $error("wake pin level wrong");
  AST_OD_LOW: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    ctrl_ff[CTRL_WAKE_OD] |=> !wakeIndicatorOut)
    else $error("open-drain drives high");
  AST_OD_OE: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    ctrl_ff[CTRL_WAKE_OD] |=> wakeIndicatorOe_n ==
    ($past(wakeReq_ff) == $past(ctrl_ff[CTRL_WAKE_POL])))
    else $error("open-drain enable wrong");
  AST_STRAP_HOLD: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    strapDone_ff |=> $stable(strap_ff))
    else $error("strap changed after latch");
  AST_STRAP_LATCH: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    strapCnt_ff == STRAP_WAIT && !strapDone_ff |=> strapDone_ff &&
    strap_ff == $past(speedSync))
    else $error("strap not latched from pin");
  AST_XOVER: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    xoverSync |=> linkCfg.autoXover)
    else $error("crossover not following pin");
  AST_TICK: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    tick |=> !tick [*3])
    else $error("reference tick spacing wrong");
  COV_OD_ASSERT: cover property (@(posedge ref_clk) disable iff (!nrst)
    ctrl_ff[CTRL_WAKE_OD] && wakeReq_ff);
  COV_STRAP_LOW: cover property (@(posedge ref_clk) disable iff (!nrst)
    strapDone_ff && !strap_ff);
  COV_SLEEP: cover property (@(posedge ref_clk) disable iff (!nrst)
    state_ff == PW_ACTIVE ##1 state_ff == PW_SLEEP);
  COV_WAKE_SLEEP: cover property (@(posedge ref_clk) disable iff (!nrst)
    state_ff == PW_SLEEP && wakeReq_ff);
  COV_RESUME: cover property (@(posedge ref_clk) disable iff (!nrst)
    state_ff == PW_SLEEP ##1 state_ff == PW_LOCKED ##[1:20]
    state_ff == PW_ACTIVE);
endmodule
`default_nettype wire

// >>> common/wake_ctrl_pkg.sv
`default_nettype none
package wake_ctrl_pkg;
  // reference rate
  localparam int REF_CLK_HZ = 100_000_000;
  localparam int REF_OSC_HZ = 25_000_000;
  localparam int OSC_DIV = REF_CLK_HZ / REF_OSC_HZ;
  localparam logic [7:0] ADDR_W = 8'h08;
  // register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
  localparam logic [7:0] REG_BYTE_TEST = 8'h64;
  localparam logic [31:0] BYTE_TEST_VAL = 32'h87654321;
  // ctrl fields
  localparam int CTRL_WAKE_EN = 0;
  localparam int CTRL_WAKE_POL = 1;
  localparam int CTRL_WAKE_OD = 2;
  localparam int CTRL_SLEEP = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;
  // irq fields
  localparam int IRQ_WAKE = 0;
  localparam int IRQ_RESUME = 1;
  localparam logic [1:0] IRQ_RST = 2'h0;
  // edges after release before the strap sync output is valid
  localparam logic [1:0] STRAP_WAIT = 2'h2;
  typedef enum logic [1:0] {
    PW_LOCKED = 2'b00,
    PW_ACTIVE = 2'b01,
    PW_SLEEP = 2'b11
  } pwr_state_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
  typedef struct packed {
    logic strapSpeed100;
    logic autoXover;
  } link_cfg_t;
endpackage
`default_nettype wire

// >>> hdl/sync_two.sv
`default_nettype none
module sync_two #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] dout_ff;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= '0;
      dout_ff <= '0;
    end else begin
      meta_ff <= din;
      dout_ff <= meta_ff;
    end
  end
  assign dout = dout_ff;
endmodule
`default_nettype wire

// >>> hdl/osc_div.sv
`default_nettype none
module osc_div #(
  parameter int DIV = 4
) (
  input wire logic ref_clk,
  input wire logic nrst,
  output logic tick
);
  localparam int CW = $clog2(DIV);
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic tick_ff;
  always_comb begin
    nxt_cnt = (cnt_ff == CW'(DIV - 1)) ? '0
      : cnt_ff + 1'b1;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= (cnt_ff == '0);
    end
  end
  assign tick = tick_ff;
endmodule
`default_nettype wire

// >>> verification/host_model.sv
`default_nettype none
module host_model
  import wake_ctrl_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // register port
  output wake_ctrl_pkg::bus_req_t busReq,
  input wire logic [31:0] rdData
);
  timeunit 1ns;
  timeprecision 1ps;
  initial busReq = '0;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    busReq <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    busReq <= '0;
    #1 d = rdData;
  endtask
  task automatic unlock(output logic [31:0] d);
    rd(REG_BYTE_TEST, d);
  endtask
  task automatic wake(input logic [31:0] d);
    wr(REG_BYTE_TEST, d);
  endtask
endmodule
`default_nettype wire

// >>> verification/wake_reset_strap_control_tb.sv
`default_nettype none
module wake_reset_strap_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import wake_ctrl_pkg::*;
  logic ref_clk, nrst, speedSelPin, crossoverAutoEnablePin, wakeEventIn;
  logic wakeIndicatorOut, wakeIndicatorOe_n, sleeping, oscTick, irq;
  bus_req_t busReq;
  logic [31:0] rdData, d;
  link_cfg_t linkCfg;
  int fails = 0;
  int totalChecks = 0;
  wake_reset_strap_control uut (.ref_clk(ref_clk), .nrst(nrst),
    .busReq(busReq), .rdData(rdData), .speedSelPin(speedSelPin),
    .crossoverAutoEnablePin(crossoverAutoEnablePin),
    .wakeEventIn(wakeEventIn), .wakeIndicatorOut(wakeIndicatorOut),
    .wakeIndicatorOe_n(wakeIndicatorOe_n), .linkCfg(linkCfg),
    .sleeping(sleeping), .oscTick(oscTick), .irq(irq));
  host_model host (.ref_clk(ref_clk), .busReq(busReq), .rdData(rdData));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic await_ind(input logic viaOe);
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      #1;
      if (viaOe ? wakeIndicatorOe_n === 1'b0 : wakeIndicatorOut === 1'b1)
        break;
    end
    if (i == 20) begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic t_reset();
    int n;
    chk(32'({rdData[0], sleeping, wakeIndicatorOe_n, irq}), 32'h2);
    @(posedge ref_clk);
    nrst <= 1'b1;
    n = 0;
    repeat (8) begin
      @(posedge ref_clk);
      #1 n += int'(oscTick === 1'b1);
    end
    chk(32'(n), 32'h2);
    $display("test reset done");
  endtask
  task automatic t_lock();
    host.wr(REG_CTRL, 32'h1);
    host.unlock(d);
    chk(d, BYTE_TEST_VAL);
    host.rd(REG_CTRL, d);
    chk(d, 32'h0);
    host.rd(REG_STAT, d);
    chk(d, 32'h13);
    chk(32'(linkCfg), 32'h2);
    host.wr(REG_CTRL, 32'h1);
    host.rd(REG_CTRL, d);
    chk(d, 32'h1);
    $display("test lock done");
  endtask
  task automatic t_pins();
    @(posedge ref_clk);
    speedSelPin <= 1'b0;
    crossoverAutoEnablePin <= 1'b1;
    repeat (6) @(posedge ref_clk);
    #1 chk(32'(linkCfg), 32'h3);
    @(posedge ref_clk);
    crossoverAutoEnablePin <= 1'b0;
    repeat (6) @(posedge ref_clk);
    #1 chk(32'(linkCfg), 32'h2);
    $display("test pins done");
  endtask
  task automatic t_wake();
    host.wr(REG_IRQ_MASK, 32'h1);
    host.wr(REG_CTRL, 32'hb);
    @(posedge ref_clk);
    #1 chk(32'(sleeping), 32'h1);
    @(posedge ref_clk);
    wakeEventIn <= 1'b1;
    await_ind(1'b0);
    @(posedge ref_clk);
    #1 chk(32'({wakeIndicatorOut, wakeIndicatorOe_n, sleeping, irq}),
      32'hb);
    @(posedge ref_clk);
    wakeEventIn <= 1'b0;
    host.wake(32'h5a5a0000);
    repeat (2) @(posedge ref_clk);
    #1 chk(32'({sleeping, wakeIndicatorOut}), 32'h0);
    host.wr(REG_CTRL, 32'h1);
    host.unlock(d);
    host.rd(REG_CTRL, d);
    chk(d, 32'h3);
    host.rd(REG_IRQ_STAT, d);
    chk(d, 32'h3);
    host.wr(REG_IRQ_STAT, 32'h3);
    @(posedge ref_clk);
    #1 chk(32'(irq), 32'h0);
    $display("test wake done");
  endtask
  task automatic t_od();
    host.wr(REG_CTRL, 32'h5);
    @(posedge ref_clk);
    #1 chk(32'(wakeIndicatorOe_n), 32'h1);
    @(posedge ref_clk);
    wakeEventIn <= 1'b1;
    await_ind(1'b1);
    chk(32'({wakeIndicatorOut, wakeIndicatorOe_n}), 32'h0);
    @(posedge ref_clk);
    wakeEventIn <= 1'b0;
    host.wr(REG_CTRL, 32'h4);
    repeat (2) @(posedge ref_clk);
    #1 chk(32'(wakeIndicatorOe_n), 32'h1);
    $display("test open drain done");
  endtask
  task automatic t_restrap();
    @(posedge ref_clk);
    nrst <= 1'b0;
    speedSelPin <= 1'b0;
    repeat (5) @(posedge ref_clk);
    #1 chk(32'({sleeping, wakeIndicatorOe_n, irq, linkCfg}),
      32'h8);
    @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    speedSelPin <= 1'b1;
    host.unlock(d);
    chk(d, BYTE_TEST_VAL);
    host.rd(REG_STAT, d);
    chk(d, 32'h11);
    chk(32'(linkCfg), 32'h0);
    $display("test restrap done");
  endtask
  initial begin
    nrst = 1'b0;
    speedSelPin = 1'b1;
    crossoverAutoEnablePin = 1'b0;
    wakeEventIn = 1'b0;
    repeat (4) @(posedge ref_clk);
    t_reset();
    t_lock();
    t_pins();
    t_wake();
    t_od();
    t_restrap();
    give_verdict();
  end
endmodule
`default_nettype wire
